//--- rtl/tdr_test_diag_registers.sv
// test and diagnostic register bank with probe pin routing
//
// Functional notes
// - bus view register reads selected test bus
// - boost bit makes receiver chain non-linear
// - boost also makes thresholds act non-linearly
// - self check enabled only by 1001b
// - checksum command launches enabled self check
// - read-only id: type high, version low
// - probe selectors: 0000 hiz, 1010 high, 1011 low
// - code 0001 routes converter a/b
// - receiver test codes; reserved codes listed
// - code 1100 shows transmit active window
// - code 1101 shows receive active window
// - code 1110 shows subcarrier detected
// - code 1111 shows selected test bus bit
// - dac a value drives probe a at 0001
// - dac b value drives probe b at 0001
// - group select picks test bus source
// - bit select picks one test bus bit
// - command 0011 runs checksum or self check
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
module tdr_test_diag_registers
   import tdr_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [ADDR_W-1:0] adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   input  wire logic [255:0]      probeGroups,
   input  wire tdr_rate_e         linkRate,
   input  wire tdr_frame_s        frameState,
   input  wire logic              correlatorOneSignal,
   input  wire logic [5:0]        minimumSignalThreshold,
   input  wire logic [3:0]        adcIValue,
   input  wire logic [3:0]        adcQValue,
   input  wire logic [3:0]        commandCode,
   input  wire logic              commandWrite,
   output logic      [4:0]        probeGroupSelect,
   output logic      [2:0]        probeBitSelect,
   output logic                   testOutputPin,
   output logic                   receiverBoost,
   output logic                   thresholdNonLinear,
   output logic                   selfCheckEnable,
   output logic                   selfCheckStart,
   output logic                   checksumStart,
   output tdr_probe_s             probePinA,
   output tdr_probe_s             probePinB
);

   logic [2:0] bitSel_q, bitSel_d;
   logic [4:0] grpSel_q, grpSel_d;
   logic       boost_q, boost_d;
   logic [3:0] selfChk_q, selfChk_d;
   logic [7:0] probeSel_q, probeSel_d;
   logic [5:0] dacA_q, dacA_d;
   logic [5:0] dacB_q, dacB_d;
   logic [31:0] rdat_q, rdat_d;
   logic        ack_q, ack_d;
   logic        chkStart_q, chkStart_d;
   logic        selfStart_q, selfStart_d;
   logic [7:0]  busView;
   logic        busBit;
   logic        req;
   logic        wrLane0;

   assign req     = cyc_i && stb_i && !ack_q;
   assign wrLane0 = req && we_i && sel_i[0];

   // test bus view, eight bits of the selected group
   assign busView = probeGroups[{grpSel_q, 3'h0} +: 8];
   assign busBit  = busView[bitSel_q];

   always_comb begin
      bitSel_d   = bitSel_q;
      grpSel_d   = grpSel_q;
      boost_d    = boost_q;
      selfChk_d  = selfChk_q;
      probeSel_d = probeSel_q;
      dacA_d     = dacA_q;
      dacB_d     = dacB_q;
      if (wrLane0) begin
         unique case (adr_i)
            REG_TEST_SEL_ONE: bitSel_d = dat_i[2:0];
            REG_TEST_SEL_TWO: grpSel_d = dat_i[4:0];
            REG_SELF_TEST: begin
               boost_d   = dat_i[BOOST_BIT];
               selfChk_d = dat_i[3:0];
            end
            REG_PROBE_SEL: probeSel_d = dat_i[7:0];
            REG_DAC_A: dacA_d = dat_i[5:0];
            REG_DAC_B: dacB_d = dat_i[5:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      ack_d  = req;
      rdat_d = 32'h0000_0000;
      if (req && !we_i) begin
         unique case (adr_i)
            REG_TEST_SEL_ONE: rdat_d[2:0] = bitSel_q;
            REG_TEST_SEL_TWO: rdat_d[4:0] = grpSel_q;
            REG_BUS_VIEW:     rdat_d[7:0] = busView;
            REG_SELF_TEST: begin
               rdat_d[BOOST_BIT] = boost_q;
               rdat_d[3:0]       = selfChk_q;
            end
            REG_CHIP_ID: rdat_d[7:0] = {CHIP_TYPE_CODE, CHIP_REV_CODE};
            REG_PROBE_SEL: rdat_d[7:0] = probeSel_q;
            REG_DAC_A: rdat_d[5:0] = dacA_q;
            REG_DAC_B: rdat_d[5:0] = dacB_q;
            default: rdat_d = 32'h0000_0000;
         endcase
      end
   end

   // checksum command start pulses
   always_comb begin
      chkStart_d  = 1'b0;
      selfStart_d = 1'b0;
      if (commandWrite && commandCode == CMD_CHECKSUM) begin
         if (selfChk_q == SELF_CHECK_ON) begin
            selfStart_d = 1'b1;
         end else begin
            chkStart_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bitSel_q    <= 3'h0;
         grpSel_q    <= 5'h00;
         boost_q     <= SELF_TEST_RESET[BOOST_BIT];
         selfChk_q   <= 4'h0;
         probeSel_q  <= 8'h00;
         dacA_q      <= 6'h00;
         dacB_q      <= 6'h00;
         rdat_q      <= 32'h0000_0000;
         ack_q       <= 1'b0;
         chkStart_q  <= 1'b0;
         selfStart_q <= 1'b0;
      end else begin
         bitSel_q    <= bitSel_d;
         grpSel_q    <= grpSel_d;
         boost_q     <= boost_d;
         selfChk_q   <= selfChk_d;
         probeSel_q  <= probeSel_d;
         dacA_q      <= dacA_d;
         dacB_q      <= dacB_d;
         rdat_q      <= rdat_d;
         ack_q       <= ack_d;
         chkStart_q  <= chkStart_d;
         selfStart_q <= selfStart_d;
      end
   end

   assign dat_o              = rdat_q;
   assign ack_o              = ack_q;
   assign probeGroupSelect   = grpSel_q;
   assign probeBitSelect     = bitSel_q;
   assign testOutputPin      = busBit;
   assign receiverBoost      = boost_q;
   assign thresholdNonLinear = boost_q;
   assign selfCheckEnable    = (selfChk_q == SELF_CHECK_ON);
   assign selfCheckStart     = selfStart_q;
   assign checksumStart      = chkStart_q;

   // activity windows by data rate
   logic txWin, rxWin, subWin;
   always_comb begin
      if (linkRate == RATE_106) begin
         txWin = frameState.txOn && (frameState.phase != PH_IDLE);
         rxWin = frameState.rxOn && (frameState.phase == PH_DATA ||
                 frameState.phase == PH_PARITY ||
                 frameState.phase == PH_CRC);
         subWin = 1'b0;
      end else begin
         txWin = frameState.txOn && (frameState.phase == PH_DATA ||
                 frameState.phase == PH_CRC);
         rxWin = frameState.rxOn && (frameState.phase == PH_DATA ||
                 frameState.phase == PH_CRC);
         subWin = frameState.subcarrierSeen && frameState.lastPart &&
                  (frameState.phase == PH_DATA ||
                   frameState.phase == PH_CRC);
      end
   end

   function automatic tdr_probe_s route(input logic [3:0] code,
                                        input logic [5:0] dac);
      tdr_probe_s p;
      p = '{kind: PK_HIZ, level: 1'b0, value: 6'h00};
      unique case (code)
         SEL_HIZ:     p.kind = PK_HIZ;
         SEL_DAC:     begin p.kind = PK_ANALOG; p.value = dac; end
         SEL_CORR:    begin p.kind = PK_DIGITAL;
                            p.level = correlatorOneSignal; end
         SEL_MINLVL:  begin p.kind = PK_ANALOG;
                            p.value = minimumSignalThreshold; end
         SEL_ADC_I:   begin p.kind = PK_ANALOG;
                            p.value = {adcIValue, 2'h0}; end
         SEL_ADC_Q:   begin p.kind = PK_ANALOG;
                            p.value = {adcQValue, 2'h0}; end
         SEL_HIGH:    begin p.kind = PK_DIGITAL; p.level = 1'b1; end
         SEL_LOW:     begin p.kind = PK_DIGITAL; p.level = 1'b0; end
         SEL_TX_ACT:  begin p.kind = PK_DIGITAL; p.level = txWin; end
         SEL_RX_ACT:  begin p.kind = PK_DIGITAL; p.level = rxWin; end
         SEL_SUBC:    begin p.kind = PK_DIGITAL; p.level = subWin; end
         SEL_BUS_BIT: begin p.kind = PK_DIGITAL; p.level = busBit; end
         default:     p.kind = PK_HIZ;
      endcase
      return p;
   endfunction

   tdr_probe_s probeA_d, probeB_d, probeA_q, probeB_q;
   always_comb begin
      probeA_d = route(probeSel_q[7:4], dacA_q);
      probeB_d = route(probeSel_q[3:0], dacB_q);
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         probeA_q <= '{kind: PK_HIZ, level: 1'b0, value: 6'h00};
         probeB_q <= '{kind: PK_HIZ, level: 1'b0, value: 6'h00};
      end else begin
         probeA_q <= probeA_d;
         probeB_q <= probeB_d;
      end
   end
   assign probePinA = probeA_q;
   assign probePinB = probeB_q;

   sequence wrSelf_s;
      wrLane0 && adr_i == REG_SELF_TEST;
   endsequence

   bus_ack_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      req |=> ack_o ##1 !ack_o)
      else $error("ack not one cycle after request");
   view_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (req && !we_i && adr_i == REG_BUS_VIEW) |=>
         dat_o[7:0] == $past(busView) && dat_o[31:8] == 24'h0)
      else $error("bus view read wrong");
   boost_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrSelf_s |=> receiverBoost == $past(dat_i[BOOST_BIT])
         && thresholdNonLinear == receiverBoost)
      else $error("boost bit not stored");
   self_enable_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrSelf_s |=> selfCheckEnable == ($past(dat_i[3:0]) == 4'h9))
      else $error("self check enable wrong");
   self_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (commandWrite && commandCode == 4'h3 && selfCheckEnable) |=>
         selfCheckStart && !checksumStart)
      else $error("self check not launched");
   id_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (req && !we_i && adr_i == REG_CHIP_ID) |=>
         dat_o == {24'h0, CHIP_TYPE_CODE, CHIP_REV_CODE})
      else $error("id read wrong");
   probe_hiz_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      probeSel_q[7:4] == 4'h0 |=> probePinA.kind == PK_HIZ)
      else $error("probe a not high impedance");
   dac_route_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      probeSel_q[3:0] == 4'h1 |=>
         probePinB.kind == PK_ANALOG && probePinB.value == $past(dacB_q))
      else $error("dac b not routed");
   bus_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      probeSel_q[7:4] == 4'hF |=> probePinA.level == $past(busBit))
      else $error("bus bit not routed");

   sequence rdSelf_s;
      req && !we_i && adr_i == REG_SELF_TEST;
   endsequence

   ack_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ack_o |=> !ack_o)
      else $error("ack held too long");

   rd_upper_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ack_o |-> dat_o[31:8] == 24'h0)
      else $error("upper read bits not zero");

   wr_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (req && we_i) |=> dat_o == 32'h0)
      else $error("write returned data");

   self_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rdSelf_s |=> dat_o[7:4] == {1'b0, $past(boost_q), 2'b00})
      else $error("self test reserved bits not zero");

   dac_a_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (req && !we_i && adr_i == REG_DAC_A) |=> dat_o[7:0] == {2'b00, $past(dacA_q)})
      else $error("dac a read wrong");

   dac_b_rd_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (req && !we_i && adr_i == REG_DAC_B) |=> dat_o[7:0] == {2'b00, $past(dacB_q)})
      else $error("dac b read wrong");

   chk_go_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (commandWrite && commandCode == CMD_CHECKSUM && !selfCheckEnable) |=> checksumStart && !selfCheckStart)
      else $error("checksum not launched");

   no_go_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !(commandWrite && commandCode == CMD_CHECKSUM) |=> !checksumStart && !selfCheckStart)
      else $error("start pulse without command");

   self_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wrSelf_s ##0 dat_i[3:0] == 4'h0) |=> !selfCheckEnable)
      else $error("self check not disabled");

   thr_nl_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrSelf_s |=> thresholdNonLinear == $past(dat_i[BOOST_BIT]))
      else $error("threshold mode not stored");

   pin_high_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      probeSel_q[7:4] == 4'hA |=> probePinA.kind == PK_DIGITAL && probePinA.level)
      else $error("probe a not high");

   pin_low_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      probeSel_q[3:0] == 4'hB |=> probePinB.kind == PK_DIGITAL && !probePinB.level)
      else $error("probe b not low");

   pa_dac_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      probeSel_q[7:4] == 4'h1 |=> probePinA.kind == PK_ANALOG && probePinA.value == $past(dacA_q))
      else $error("dac a not routed");

   resv_hiz_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (probeSel_q[7:4] inside {4'h3, 4'h7, 4'h8, 4'h9}) |=> probePinA.kind == PK_HIZ)
      else $error("reserved code drives probe a");

   corr_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      probeSel_q[3:0] == 4'h2 |=> probePinB.level == $past(correlatorOneSignal))
      else $error("correlator not routed");

   min_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      probeSel_q[7:4] == 4'h4 |=> probePinA.value == $past(minimumSignalThreshold))
      else $error("minimum level not routed");

   tx_win_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (probeSel_q[7:4] == 4'hC && linkRate != RATE_106 && frameState.phase == PH_START) |=> !probePinA.level)
      else $error("transmit window wrong");

   rx_win_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (probeSel_q[3:0] == 4'hD && linkRate == RATE_106 && frameState.phase == PH_START) |=> !probePinB.level)
      else $error("receive window wrong");

   sub_slow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (probeSel_q[7:4] == 4'hE && linkRate == RATE_106) |=> !probePinA.level)
      else $error("subcarrier flag at low rate");

   sel_skip_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (req && we_i && !sel_i[0] && adr_i == REG_DAC_A) |=> $stable(dacA_q))
      else $error("write without lane stored");

   view_ro_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wrLane0 && adr_i == REG_BUS_VIEW) |=> $stable({grpSel_q, bitSel_q}))
      else $error("bus view write changed selects");

   grp_out_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wrLane0 && adr_i == REG_TEST_SEL_TWO) |=> probeGroupSelect == $past(dat_i[4:0]))
      else $error("group select not stored");

   bit_out_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wrLane0 && adr_i == REG_TEST_SEL_ONE) |=> probeBitSelect == $past(dat_i[2:0]))
      else $error("bit select not stored");

   test_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      testOutputPin == probeGroups[{probeGroupSelect, probeBitSelect}])
      else $error("test output pin wrong");
endmodule

//--- rtl/tdr_pkg.sv
// package for the test and diagnostic register bank
package tdr_pkg;
   localparam logic [7:0] REG_TEST_SEL_ONE  = 8'h31;
   localparam logic [7:0] REG_TEST_SEL_TWO  = 8'h32;
   localparam logic [7:0] REG_BUS_VIEW      = 8'h35;
   localparam logic [7:0] REG_SELF_TEST     = 8'h36;
   localparam logic [7:0] REG_CHIP_ID       = 8'h37;
   localparam logic [7:0] REG_PROBE_SEL     = 8'h38;
   localparam logic [7:0] REG_DAC_A         = 8'h39;
   localparam logic [7:0] REG_DAC_B         = 8'h3A;
   localparam logic [7:0] REG_COMMAND       = 8'h01;
   localparam int         ADDR_W            = 8;
   localparam logic [7:0] SELF_TEST_RESET   = 8'h40;
   localparam int         BOOST_BIT         = 6;
   localparam logic [3:0] SELF_CHECK_ON     = 4'h9;
   localparam logic [3:0] CMD_CHECKSUM      = 4'h3;
   localparam logic [3:0] CHIP_TYPE_CODE    = 4'hA; // arbitrary value
   localparam logic [3:0] CHIP_REV_CODE     = 4'h1; // arbitrary value
   localparam logic [3:0] SEL_HIZ           = 4'h0;
   localparam logic [3:0] SEL_DAC           = 4'h1;
   localparam logic [3:0] SEL_CORR          = 4'h2;
   localparam logic [3:0] SEL_MINLVL        = 4'h4;
   localparam logic [3:0] SEL_ADC_I         = 4'h5;
   localparam logic [3:0] SEL_ADC_Q         = 4'h6;
   localparam logic [3:0] SEL_HIGH          = 4'hA;
   localparam logic [3:0] SEL_LOW           = 4'hB;
   localparam logic [3:0] SEL_TX_ACT        = 4'hC;
   localparam logic [3:0] SEL_RX_ACT        = 4'hD;
   localparam logic [3:0] SEL_SUBC          = 4'hE;
   localparam logic [3:0] SEL_BUS_BIT       = 4'hF;
   typedef enum logic [1:0] {
      RATE_106, RATE_212, RATE_424, RATE_848
   } tdr_rate_e;
   typedef enum logic [2:0] {
      PH_IDLE, PH_START, PH_DATA, PH_PARITY, PH_CRC
   } tdr_phase_e;
   // frame state reported by the framing logic
   typedef struct packed {
      logic       txOn;
      logic       rxOn;
      logic       subcarrierSeen;
      logic       lastPart;
      tdr_phase_e phase;
   } tdr_frame_s;
   // analog probe pin drive: kind of source and level
   typedef enum logic [1:0] {
      PK_HIZ, PK_DIGITAL, PK_ANALOG
   } tdr_probe_kind_e;
   typedef struct packed {
      tdr_probe_kind_e kind;
      logic            level;
      logic [5:0]      value;
   } tdr_probe_s;
endpackage

//--- tb/tdr_testbench.sv
// self-checking bench for the test and diagnostic register bank
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
   import tdr_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} tdr_row_s;
   logic            sys_clk = 1'b0;
   logic            rst_b = 1'b0;
   logic            cyc = 1'b0;
   logic            stb = 1'b0;
   logic            we = 1'b0;
   logic            cw = 1'b0;
   logic            corr = 1'b1;
   logic [7:0]      adr = 8'h00;
   logic [7:0]      q;
   logic [3:0]      sel = 4'h1;
   logic [3:0]      cmd = 4'h0;
   logic [3:0]      adcI = 4'hB;
   logic [3:0]      adcQ = 4'h6;
   logic [5:0]      minThr = 6'h2D;
   logic [31:0]     wdat = 32'h0;
   logic [31:0]     rdat;
   logic            ack;
   logic [255:0]    groups;
   tdr_rate_e       rate = RATE_212;
   tdr_frame_s      frame;
   logic [4:0]      grpSel;
   logic [2:0]      bitSel;
   logic            tpin, boost, thrNl, scEn, scGo, ckGo;
   tdr_probe_s      pa, pb;
   int              n_errors = 0;
   int              n_compared = 0;
   tdr_row_s        rows [10] = '{
      '{REG_SELF_TEST, 8'hFF, 8'h4F}, '{REG_SELF_TEST, 8'h49, 8'h49},
      '{REG_PROBE_SEL, 8'h5A, 8'h5A}, '{REG_DAC_A, 8'hFF, 8'h3F},
      '{REG_DAC_B, 8'hC5, 8'h05}, '{REG_TEST_SEL_ONE, 8'hFF, 8'h07},
      '{REG_TEST_SEL_TWO, 8'hFF, 8'h1F},
      '{REG_CHIP_ID, 8'h00, {CHIP_TYPE_CODE, CHIP_REV_CODE}},
      '{REG_BUS_VIEW, 8'h00, 8'hBA}, '{8'h50, 8'h12, 8'h00}};
   tdr_rate_e       rt [5] = '{RATE_106, RATE_106, RATE_212, RATE_424, RATE_848};
   tdr_phase_e      ph [5] = '{PH_START, PH_PARITY, PH_START, PH_PARITY, PH_CRC};
   logic [1:0]      ex [5] = '{2'b10, 2'b11, 2'b00, 2'b00, 2'b11};

   always #2.5 sys_clk = ~sys_clk;

   tdr_test_diag_registers dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .probeGroups(groups), .linkRate(rate), .frameState(frame),
      .correlatorOneSignal(corr), .minimumSignalThreshold(minThr),
      .adcIValue(adcI), .adcQValue(adcQ), .commandCode(cmd),
      .commandWrite(cw), .probeGroupSelect(grpSel), .probeBitSelect(bitSel),
      .testOutputPin(tpin), .receiverBoost(boost), .thresholdNonLinear(thrNl),
      .selfCheckEnable(scEn), .selfCheckStart(scGo), .checksumStart(ckGo),
      .probePinA(pa), .probePinB(pb));

   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one classic cycle; waits for ack under a bound
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s = 4'h1);
      int k;
      k = 0;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= {24'h0, d};
      do begin
         @(posedge sys_clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (k >= 20) begin
         n_errors++;
         complete_run();
      end
   endtask

   task automatic command(input logic [3:0] c, input logic [1:0] e);
      @(posedge sys_clk);
      cmd <= c;
      cw <= 1'b1;
      @(posedge sys_clk);
      cw <= 1'b0;
      @(negedge sys_clk);
      `CHK({scGo, ckGo}, e)
      @(negedge sys_clk);
      `CHK({scGo, ckGo}, 2'b00)
   endtask

   task automatic chkProbe(input tdr_probe_s p, input logic [3:0] c,
                           input logic [5:0] dac, input logic b);
      logic [1:0] ek;
      logic [6:0] m;
      logic [6:0] ev;
      {ek, m, ev} = {PK_DIGITAL, 7'h40, 7'h40};
      case (c)
         SEL_DAC:     {ek, m, ev} = {PK_ANALOG, 7'h3F, 1'b0, dac};
         SEL_MINLVL:  {ek, m, ev} = {PK_ANALOG, 7'h3F, 1'b0, minThr};
         SEL_ADC_I:   {ek, m, ev} = {PK_ANALOG, 7'h3F, 1'b0, adcI, 2'b00};
         SEL_ADC_Q:   {ek, m, ev} = {PK_ANALOG, 7'h3F, 1'b0, adcQ, 2'b00};
         SEL_LOW:     ev = 7'h00;
         SEL_BUS_BIT: ev = {b, 6'h00};
         SEL_CORR:    ev = {corr, 6'h00};
         SEL_HIGH, SEL_TX_ACT, SEL_RX_ACT, SEL_SUBC: ek = PK_DIGITAL;
         default:     {ek, m, ev} = {PK_HIZ, 14'h0};
      endcase
      `CHK(p.kind, ek)
      `CHK({p.level, p.value} & m, ev)
   endtask

   initial begin
      for (int g = 0; g < 32; g++)
         groups[8*g +: 8] = 8'(g) ^ 8'hA5;
      frame = {1'b1, 1'b1, 1'b1, 1'b1, PH_DATA};
      repeat (5) @(posedge sys_clk);
      `CHK({boost, thrNl, scEn, pa.kind, pb.kind}, 7'h60)
      rst_b <= 1'b1;
      wb(1'b0, REG_SELF_TEST, 8'h00);
      `CHK(q, SELF_TEST_RESET)
      wb(1'b0, REG_DAC_A, 8'h00);
      `CHK(q, 8'h00)
      $display("test reset done");
      foreach (rows[i]) begin
         wb(1'b1, rows[i].a, rows[i].d);
         wb(1'b0, rows[i].a, 8'h00);
         `CHK(q, rows[i].e)
      end
      @(negedge sys_clk);
      `CHK({boost, thrNl, scEn, grpSel, bitSel}, 11'h7FF)
      $display("test rows done");
      command(CMD_CHECKSUM, 2'b10);
      command(4'h4, 2'b00);
      wb(1'b1, REG_SELF_TEST, 8'h48);
      command(CMD_CHECKSUM, 2'b01);
      wb(1'b1, REG_SELF_TEST, 8'h00);
      @(negedge sys_clk);
      `CHK({boost, thrNl, scEn}, 3'b000)
      $display("test self check done");
      wb(1'b1, REG_DAC_A, 8'h11, 4'hE);
      wb(1'b0, REG_DAC_A, 8'h00);
      `CHK(q, 8'h3F)
      $display("test byte select done");
      wb(1'b1, REG_DAC_A, 8'h2A);
      wb(1'b1, REG_DAC_B, 8'h15);
      for (int c = 0; c < 16; c++) begin
         wb(1'b1, REG_PROBE_SEL, {c[3:0], c[3:0]});
         @(negedge sys_clk);
         chkProbe(pa, c[3:0], 6'h2A, groups[255]);
         chkProbe(pb, c[3:0], 6'h15, groups[255]);
      end
      $display("test probe codes done");
      for (int b = 0; b < 8; b++) begin
         wb(1'b1, REG_TEST_SEL_ONE, 8'(b));
         @(negedge sys_clk);
         `CHK({tpin, pa.level, pb.level}, {3{groups[248+b]}})
      end
      wb(1'b1, REG_TEST_SEL_TWO, 8'h03);
      wb(1'b0, REG_BUS_VIEW, 8'h00);
      `CHK(q, 8'h03 ^ 8'hA5)
      $display("test bus select done");
      wb(1'b1, REG_PROBE_SEL, {SEL_TX_ACT, SEL_RX_ACT});
      foreach (rt[i]) begin
         @(posedge sys_clk);
         rate <= rt[i];
         frame.phase <= ph[i];
         repeat (3) @(negedge sys_clk);
         `CHK({pa.level, pb.level}, ex[i])
      end
      $display("test activity windows done");
      complete_run();
   end
endmodule
